/* common/lss_pkg.sv */
// package: register map, field layout and line condition codes of the line state status block
package lss_pkg;

	// ==========================================
	// register map (byte addresses)
	localparam int LSS_AW = 8;
	localparam logic [LSS_AW-1:0] LSS_ADDR_STATUS = 8'h10;
	localparam logic [LSS_AW-1:0] LSS_ADDR_IRQ_STAT = 8'h14;
	localparam logic [LSS_AW-1:0] LSS_ADDR_IRQ_MASK = 8'h18;

	// ==========================================
	// current line condition codes
	localparam logic [2:0] LSS_COND_NOISE = 3'h0;
	localparam logic [2:0] LSS_COND_ACTIVE = 3'h1;
	localparam logic [2:0] LSS_COND_UNDEF = 3'h2;
	localparam logic [2:0] LSS_COND_SHORT_IDLE = 3'h3;
	localparam logic [2:0] LSS_COND_QUIET = 3'h4;
	localparam logic [2:0] LSS_COND_MASTER = 3'h5;
	localparam logic [2:0] LSS_COND_HALT = 3'h6;
	localparam logic [2:0] LSS_COND_LONG_IDLE = 3'h7;

	// previous line condition codes
	localparam logic [1:0] LSS_PREV_QUIET = 2'h0;
	localparam logic [1:0] LSS_PREV_MASTER = 2'h1;
	localparam logic [1:0] LSS_PREV_HALT = 2'h2;
	localparam logic [1:0] LSS_PREV_LONG_IDLE = 2'h3;

	// ==========================================
	// like pair counter
	localparam logic [2:0] LSS_PAIR_FIRST = 3'h0;
	localparam logic [2:0] LSS_PAIR_SHORT_IDLE = 3'h1;
	localparam logic [2:0] LSS_PAIR_FULL = 3'h7;

	// interrupt status / mask bits
	localparam int LSS_IRQ_W = 2;
	localparam int LSS_IRQ_COND = 0;
	localparam int LSS_IRQ_LOSS = 1;

	// ==========================================
	// class of a decoded symbol pair, delivered by the receive decoder
	typedef enum logic [2:0] {
		lss_pair_quiet,
		lss_pair_master,
		lss_pair_halt,
		lss_pair_idle,
		lss_pair_noise,
		lss_pair_active
	} lss_pair_t;

	typedef enum logic {
		lss_sm_hunt,
		lss_sm_held
	} lss_sm_t;

	// line_state_status layout, bit 15 first
	typedef struct packed {
		logic [4:0] revision_field;
		logic loss_of_signal;
		logic [1:0] previous_line_condition;
		logic [2:0] current_line_condition;
		logic condition_machine_state_bit;
		logic unknown_condition_flag;
		logic [2:0] like_pair_counter;
	} lss_status_t;

endpackage : lss_pkg

/* rtl/lss_sync2.sv */
// two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ns
`default_nettype none
module lss_sync2 (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// level
	input wire logic d,
	output logic q
);
	logic meta;

	// meta is read by q alone
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta <= 1'b0;
			q <= 1'b0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule : lss_sync2
`default_nettype wire

/* rtl/lss_status_reg.sv */
// line state status register with its line condition machine, apb slave and interrupt
//
// The APB register port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module lss_status_reg
	import lss_pkg::*;
#(
	// arbitrary value, identifies this variant
	parameter logic [4:0] REVISION = 5'h0a
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic [LSS_AW-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// receive line
	input wire logic pair_valid,
	input wire lss_pair_t pair_class,
	input wire logic detect_input_pin,
	// interrupt
	output logic irq
);

	// ==========================================
	// functions
	function automatic logic [2:0] cond_of(input lss_pair_t c);
		unique case (c)
			lss_pair_quiet: cond_of = LSS_COND_QUIET;
			lss_pair_master: cond_of = LSS_COND_MASTER;
			lss_pair_halt: cond_of = LSS_COND_HALT;
			lss_pair_idle: cond_of = LSS_COND_LONG_IDLE;
			lss_pair_noise: cond_of = LSS_COND_NOISE;
			lss_pair_active: cond_of = LSS_COND_ACTIVE;
			default: cond_of = LSS_COND_UNDEF;
		endcase
	endfunction : cond_of

	// quiet, master, halt and long idle are the conditions that get remembered
	function automatic logic is_kept(input logic [2:0] c);
		is_kept = (c == LSS_COND_QUIET) || (c == LSS_COND_MASTER) ||
			(c == LSS_COND_HALT) || (c == LSS_COND_LONG_IDLE);
	endfunction : is_kept

	function automatic logic [1:0] prev_of(input logic [2:0] c);
		unique case (c)
			LSS_COND_QUIET: prev_of = LSS_PREV_QUIET;
			LSS_COND_MASTER: prev_of = LSS_PREV_MASTER;
			LSS_COND_HALT: prev_of = LSS_PREV_HALT;
			default: prev_of = LSS_PREV_LONG_IDLE;
		endcase
	endfunction : prev_of

	// ==========================================
	// signal detect synchroniser
	logic detect_sync;
	logic detect_seen;

	lss_sync2 u_detect_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d(detect_input_pin),
		.q(detect_sync)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			detect_seen <= 1'b0;
		end else begin
			detect_seen <= detect_sync;
		end
	end

	// ==========================================
	// line condition machine
	lss_sm_t sm;
	lss_pair_t last_class;
	logic [2:0] pair_cnt;
	logic [2:0] cur_cond;
	logic [2:0] next_cond;
	logic [1:0] prev_cond;
	logic unknown;
	logic like_pair;
	logic recognise;

	assign like_pair = pair_valid && (pair_class == last_class);

	// recognition happens on the eighth like pair; idle also on its second
	always_comb begin
		recognise = 1'b0;
		next_cond = cur_cond;
		if (like_pair && pair_cnt == LSS_PAIR_FULL - 3'h1) begin
			recognise = 1'b1;
			next_cond = cond_of(pair_class);
		end else if (like_pair && pair_class == lss_pair_idle && pair_cnt == LSS_PAIR_FIRST) begin
			recognise = 1'b1;
			next_cond = LSS_COND_SHORT_IDLE;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_class <= lss_pair_noise;
			pair_cnt <= LSS_PAIR_FIRST;
		end else if (pair_valid) begin
			last_class <= pair_class;
			if (!like_pair) begin
				pair_cnt <= LSS_PAIR_FIRST;
			end else if (pair_cnt != LSS_PAIR_FULL) begin
				pair_cnt <= pair_cnt + 3'h1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sm <= lss_sm_hunt;
			unknown <= 1'b1;
		end else if (pair_valid && !like_pair) begin
			sm <= lss_sm_hunt;
			unknown <= 1'b1;
		end else if (recognise) begin
			sm <= lss_sm_held;
			unknown <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur_cond <= LSS_COND_NOISE;
		end else begin
			cur_cond <= next_cond;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_cond <= LSS_PREV_QUIET;
		end else if (next_cond != cur_cond && is_kept(cur_cond)) begin
			prev_cond <= prev_of(cur_cond);
		end
	end

	// ==========================================
	// status view; every field but the constant revision is a flop of this clock, so a read is coherent
	lss_status_t stat;

	always_comb begin
		stat.revision_field = REVISION;
		stat.loss_of_signal = !detect_sync;
		stat.previous_line_condition = prev_cond;
		stat.current_line_condition = cur_cond;
		stat.condition_machine_state_bit = (sm == lss_sm_hunt);
		stat.unknown_condition_flag = unknown;
		stat.like_pair_counter = pair_cnt;
	end

	// ==========================================
	// interrupt: condition change and detect change
	logic [LSS_IRQ_W-1:0] irq_stat;
	logic [LSS_IRQ_W-1:0] irq_mask;
	logic [LSS_IRQ_W-1:0] irq_event;
	logic [LSS_IRQ_W-1:0] irq_clear;
	logic done;
	logic setup;

	assign setup = psel && !penable;
	assign done = psel && penable && pready;

	always_comb begin
		irq_event = '0;
		irq_event[LSS_IRQ_COND] = (next_cond != cur_cond);
		irq_event[LSS_IRQ_LOSS] = (detect_sync != detect_seen);
		irq_clear = '0;
		if (done && !pwrite && paddr == LSS_ADDR_IRQ_STAT) begin
			// only bits that were actually returned are cleared
			irq_clear = prdata[LSS_IRQ_W-1:0];
		end
	end

	// a new event in the clearing cycle survives
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat <= '0;
		end else begin
			irq_stat <= (irq_stat & ~irq_clear) | irq_event;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask <= '0;
		end else if (done && pwrite && paddr == LSS_ADDR_IRQ_MASK) begin
			irq_mask <= pwdata[LSS_IRQ_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat & irq_mask);
		end
	end

	// ==========================================
	// apb slave: one wait-free access phase, data captured at setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= setup;
			pslverr <= 1'b0;
			if (setup) begin
				prdata <= '0;
				unique case (paddr)
					LSS_ADDR_STATUS: begin
						prdata[$bits(lss_status_t)-1:0] <= stat;
						pslverr <= 1'b0;
					end
					LSS_ADDR_IRQ_STAT: prdata[LSS_IRQ_W-1:0] <= irq_stat;
					LSS_ADDR_IRQ_MASK: prdata[LSS_IRQ_W-1:0] <= irq_mask;
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end

	// ==========================================
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_status_read_data: assert property (
		(setup && !pwrite && paddr == LSS_ADDR_STATUS) |=>
			(prdata[15:0] == $past(stat) && prdata[31:16] == 16'h0000 && pready && !pslverr)
	) else $error("status read returned wrong data");

	a_revision_on_bus: assert property (
		(done && !pwrite && paddr == LSS_ADDR_STATUS) |-> prdata[15:11] == REVISION
	) else $error("revision field wrong on bus");

	a_loss_inverted: assert property (
		($stable(detect_input_pin))[*3] ##0 $past(presetn, 3) |-> stat.loss_of_signal == !detect_input_pin
	) else $error("loss bit does not invert detect input");

	a_prev_hold: assert property (
		($changed(cur_cond) && !is_kept($past(cur_cond))) |-> $stable(prev_cond)
	) else $error("previous condition changed wrongly");

	a_prev_load: assert property (
		($changed(cur_cond) && is_kept($past(cur_cond))) |-> prev_cond == $past(cur_cond[1:0])
	) else $error("previous condition code wrong");

	a_long_idle_entry: assert property (
		(cur_cond == LSS_COND_LONG_IDLE && $past(cur_cond) != LSS_COND_LONG_IDLE) |->
			(pair_cnt == LSS_PAIR_FULL && last_class == lss_pair_idle)
	) else $error("long idle recognised too early");

	a_unknown_set: assert property (
		(pair_valid && pair_class != last_class) |=> unknown ##0 stat.condition_machine_state_bit
	) else $error("unknown flag not set on new pair class");

	a_unknown_clear: assert property (
		$changed(cur_cond) |-> !unknown
	) else $error("unknown flag set after recognition");

	a_count_step: assert property (
		(like_pair && pair_cnt != LSS_PAIR_FULL) |=> pair_cnt == $past(pair_cnt) + 3'h1
	) else $error("like pair counter did not step");

	a_status_no_write: assert property (
		(done && pwrite && paddr == LSS_ADDR_STATUS && !pair_valid) |=> $stable(cur_cond) && $stable(prev_cond)
	) else $error("write changed status register");

	c_long_idle: cover property (cur_cond == LSS_COND_SHORT_IDLE ##[1:20] cur_cond == LSS_COND_LONG_IDLE);
	c_prev_load: cover property ($changed(prev_cond));
	c_irq_raise: cover property ($rose(irq));
	c_irq_clear: cover property (done && !pwrite && paddr == LSS_ADDR_IRQ_STAT && prdata[LSS_IRQ_W-1:0] != '0);

endmodule : lss_status_reg
`default_nettype wire

/* testbench/line_state_status_register_tb_top.sv */
// self-checking testbench for the line state status register block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
module line_state_status_register_tb_top
	import lss_pkg::*;
;
	// arbitrary value, identifies this variant
	localparam logic [4:0] REV = 5'h15;
	logic pclk, presetn, psel, penable, pwrite, pair_valid, detect_input_pin, pready, pslverr, irq, err;
	logic [LSS_AW-1:0] paddr;
	logic [31:0] pwdata, prdata, rd, rd_prev;
	lss_pair_t pair_class, c, m_last;
	logic [2:0] m_cur, m_cnt;
	logic [1:0] m_prev;
	logic m_unk;
	int fail_count, tests_run;

	lss_status_reg #(.REVISION(REV)) uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pair_valid(pair_valid), .pair_class(pair_class),
		.detect_input_pin(detect_input_pin), .irq(irq));

	// ==========================================
	// expectations
	function automatic logic [2:0] code_of(input lss_pair_t p);
		case (p)
			lss_pair_quiet: return LSS_COND_QUIET;
			lss_pair_master: return LSS_COND_MASTER;
			lss_pair_halt: return LSS_COND_HALT;
			lss_pair_idle: return LSS_COND_LONG_IDLE;
			lss_pair_active: return LSS_COND_ACTIVE;
			default: return LSS_COND_NOISE;
		endcase
	endfunction : code_of

	// the loss bit lags the pin by two flops, so callers wait before reading
	function automatic logic [31:0] exp_status();
		return {16'h0000, REV, ~detect_input_pin, m_prev, m_cur, m_unk, m_unk, m_cnt};
	endfunction : exp_status

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_of_test

	// ==========================================
	// drivers
	task automatic apb(input logic w, input logic [LSS_AW-1:0] a, input logic [31:0] wd,
		output logic [31:0] d, output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			fail_count++;
			end_of_test();
		end
		d = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd_status();
		apb(1'b0, LSS_ADDR_STATUS, 32'h0, rd, err);
	endtask : rd_status

	// one pair per call; the model follows the like pair counting
	task automatic step(input lss_pair_t p);
		logic [2:0] nc;
		@(posedge pclk);
		pair_valid <= 1'b1;
		pair_class <= p;
		if (p != m_last) begin
			m_cnt = 3'h0;
			m_unk = 1'b1;
		end else if (m_cnt != LSS_PAIR_FULL) begin
			m_cnt = m_cnt + 3'h1;
			if (m_cnt == LSS_PAIR_FULL || (p == lss_pair_idle && m_cnt == LSS_PAIR_SHORT_IDLE)) begin
				nc = (m_cnt == LSS_PAIR_FULL) ? code_of(p) : LSS_COND_SHORT_IDLE;
				if (m_cur[2] && nc != m_cur)
					m_prev = m_cur[1:0];
				m_cur = nc;
				m_unk = 1'b0;
			end
		end
		m_last = p;
	endtask : step

	task automatic gap();
		@(posedge pclk);
		pair_valid <= 1'b0;
	endtask : gap

	// ==========================================
	// stimulus
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	initial begin
		presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
		pair_valid = 1'b0; pair_class = lss_pair_noise; detect_input_pin = 1'b1;
		fail_count = 0; tests_run = 0;
		m_cur = LSS_COND_NOISE; m_prev = LSS_PREV_QUIET; m_cnt = 3'h0; m_unk = 1'b1; m_last = lss_pair_noise;
		void'($urandom(72010));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		apb(1'b0, LSS_ADDR_IRQ_MASK, 32'h0, rd, err);
		`CHK("mask reset", 32'h0, rd)
		apb(1'b1, LSS_ADDR_STATUS, 32'hffff_ffff, rd, err);
		`CHK("status write error", 1'b0, err)
		rd_status();
		`CHK("status", exp_status(), rd)
		apb(1'b0, 8'h1c, 32'h0, rd, err);
		`CHK("unmapped error", 1'b1, err)
		apb(1'b0, LSS_ADDR_IRQ_STAT, 32'h0, rd, err);
		apb(1'b1, LSS_ADDR_IRQ_MASK, 32'h3, rd, err);
		apb(1'b0, LSS_ADDR_IRQ_MASK, 32'h0, rd, err);
		`CHK("mask", 32'h3, rd)
		// signal lost: loss bit set after the synchroniser, loss event raises the interrupt
		detect_input_pin <= 1'b0;
		repeat (4) @(posedge pclk);
		rd_status();
		`CHK("status signal lost", exp_status(), rd)
		`CHK("status read error", 1'b0, err)
		`CHK("irq on loss", 1'b1, irq)
		apb(1'b0, LSS_ADDR_IRQ_STAT, 32'h0, rd, err);
		`CHK("irq loss bit", 1'b1, rd[LSS_IRQ_LOSS])
		for (int i = 0; i < 16; i++) begin
			// every class once in a fixed order, then random changes of class
			if (i < 6)
				c = lss_pair_t'(3'(i));
			else
				do c = lss_pair_t'(3'($urandom_range(5, 0))); while (c == m_last);
			if (i >= 6 && $urandom_range(3, 0) == 0) begin
				detect_input_pin <= ~detect_input_pin;
				repeat (4) @(posedge pclk);
			end
			step(c);
			gap();
			rd_status();
			`CHK("status first pair", exp_status(), rd)
			step(c);
			gap();
			rd_status();
			`CHK("status second pair", exp_status(), rd)
			repeat (6) step(c);
			gap();
			rd_status();
			`CHK("status recognised", exp_status(), rd)
			`CHK("irq raised", 1'b1, irq)
			apb(1'b0, LSS_ADDR_IRQ_STAT, 32'h0, rd, err);
			`CHK("irq condition bit", 1'b1, rd[LSS_IRQ_COND])
			repeat (2) @(posedge pclk);
			`CHK("irq cleared", 1'b0, irq)
		end
		// masked event: status bit sets but the output stays low
		apb(1'b1, LSS_ADDR_IRQ_MASK, 32'h0, rd, err);
		c = (m_last == lss_pair_halt) ? lss_pair_master : lss_pair_halt;
		repeat (8) step(c);
		gap();
		repeat (3) @(posedge pclk);
		`CHK("irq masked", 1'b0, irq)
		apb(1'b0, LSS_ADDR_IRQ_STAT, 32'h0, rd, err);
		`CHK("masked event bit", 1'b1, rd[LSS_IRQ_COND])
		rd_status();
		rd_prev = rd;
		rd_status();
		`CHK("status reread", rd_prev, rd)
		`CHK("status final", exp_status(), rd)
		end_of_test();
	end
endmodule : line_state_status_register_tb_top
`default_nettype wire
